//--- sbsd_pkg.sv
// Constants for the serial bit-rate, status and data block
package sbsd_pkg;
  // Word index of each register, byte address = index * 4
  localparam logic [1:0] REG_BAUD = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h3;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 3;
  localparam int MAP_TOP = 4;
  // bit_rate_config fields
  localparam int BR_PRE_LSB = 4;
  localparam int BR_PRE_MSB = 6;
  localparam int BR_RATE_MSB = 3;
  localparam logic [7:0] BR_MASK = 8'h7F;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [3:0] RATE_MAX = 4'h8;
  // serial_status fields
  localparam int ST_RXF = 7;
  localparam int ST_TXE = 5;
  localparam int ST_MODE_FAULT_FLAG = 4;
  // first_control_register fields
  localparam int CT_EN = 6;
  localparam int CT_TIE = 5;
  localparam int CT_MASTER_SELECT = 4;
  localparam int CT_SELECT_OUTPUT_ENABLE = 1;
  localparam int CT_FDE = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Transfer shape and timing
  localparam logic [3:0] BITS_PER_XFER = 4'h8;
  localparam int TXE_SET_CYCLES = 2;
  // Synchroniser reset levels, order {ss, sck, mosi, miso}
  localparam logic [3:0] PIN_RST = 4'h8;
  localparam int PIN_SS = 3;
  localparam int PIN_SCK = 2;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 0;
  typedef enum logic [1:0] {S_IDLE, S_MXFER, S_SXFER} sbsd_state_t;
endpackage

//--- sbsd_core.sv
// Serial interface: bit-rate generator, status flags and data buffers
// Summary of operation
// - Bit-rate register readable and writable anytime
// - Prescale bits 6:4 divide by code plus one
// - Rate bits divide by 2^(code+1), max 512
// - Divider output clocks master serial bits
// - Status bits 6,3:0 read zero; writes ignored
// - Receive-full sets when a transfer completes
// - Receive-full clears: status read, then data read
// - Transmit-empty clears: status read, then data write
// - Data write without armed status read is dropped
// - Interrupt when transmit-empty and its enable set
// - Buffer-to-shifter move sets transmit-empty
// - Idle write moves at once, flag back in two
// - Shifter done pulls queued byte, else nothing
// - Mode fault on select low in fault config
// - Mode fault clears: status read, control write
// - Data reads receive buffer, writes transmit buffer
// - Master starts transfer when data is written
// - Unread buffer at transfer end drops new byte
// - Disable aborts, empties buffers, resets all flags but mode fault
// - Mode fault drops master, sck and mosi outputs, aborts to idle
// - Eight bit cycles per transfer, then receive
module sbsd_core #(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic ssIn,
  output logic ssOut,
  output logic select_output_enable,
  // Transmit interrupt request
  output logic txIrq
);
  // The unmapped-address slice needs at least one bit above the index
  if (ADR_W <= sbsd_pkg::MAP_TOP) begin : gBadAdr
    $error("ADR_W too small for the register map");
  end

  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic [3:0] pinRaw;
  logic sckPrev;
  logic [7:0] baudReg;
  logic [7:0] ctrlReg;
  logic [7:0] txBuf;
  logic [7:0] rxBuf;
  logic [7:0] shifter;
  logic txBufFull, shiftLoaded, txEmpty, rxFull, mode_fault_flag;
  logic txArm, rxArm, modfArm;
  logic sampleBit, sckReg, ackReg;
  logic [2:0] preCnt;
  logic [7:0] divCnt;
  logic [3:0] shiftCnt;
  sbsd_pkg::sbsd_state_t state;
  logic access, rdAcc, wrAcc, mapped;
  logic [1:0] idx;
  logic en, master, fde, soe, tie;
  logic [3:0] rateSel;
  logic [7:0] halfLimit;
  logic halfTick, rise, fall, inBit, xferDone, abort, modfEvent, move;
  logic statusRd, dataRd, dataWr, dataWrOk, ctrlWr, rxClear;
  logic [7:0] rxByte;

  // Pin synchronisers
  assign pinRaw = {ssIn, sckIn, mosiIn, misoIn};
  for (genvar i = 0; i < 4; i++) begin : gSync
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        pinMeta[i] <= sbsd_pkg::PIN_RST[i];
        pinSync[i] <= sbsd_pkg::PIN_RST[i];
      end else begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= pinSync[sbsd_pkg::PIN_SCK];
    end
  end

  // Bus decode; one wait state, effects land on the edge that raises ack
  assign access = cyc_i & stb_i & ~ackReg;
  assign mapped = adr_i[ADR_W-1:sbsd_pkg::MAP_TOP] == '0;
  assign idx = adr_i[sbsd_pkg::IDX_MSB:sbsd_pkg::IDX_LSB];
  assign rdAcc = access & ~we_i & mapped;
  assign wrAcc = access & we_i & sel_i[0] & mapped;
  assign statusRd = rdAcc && idx == sbsd_pkg::REG_STATUS;
  assign dataRd = rdAcc && idx == sbsd_pkg::REG_DATA;
  assign dataWr = wrAcc && idx == sbsd_pkg::REG_DATA;
  assign ctrlWr = wrAcc && idx == sbsd_pkg::REG_CTRL;
  assign dataWrOk = dataWr & txArm;
  assign rxClear = dataRd & rxArm;
  assign ack_o = ackReg;

  assign en = ctrlReg[sbsd_pkg::CT_EN];
  assign master = ctrlReg[sbsd_pkg::CT_MASTER_SELECT];
  assign fde = ctrlReg[sbsd_pkg::CT_FDE];
  assign soe = ctrlReg[sbsd_pkg::CT_SELECT_OUTPUT_ENABLE];
  assign tie = ctrlReg[sbsd_pkg::CT_TIE];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
      dat_o <= '0;
    end else begin
      ackReg <= access;
      if (access && !we_i) begin
        dat_o <= '0;
        if (mapped) begin
          unique case (idx)
            sbsd_pkg::REG_BAUD: dat_o[7:0] <= baudReg;
            sbsd_pkg::REG_STATUS: begin
              dat_o[sbsd_pkg::ST_RXF] <= rxFull;
              dat_o[sbsd_pkg::ST_TXE] <= txEmpty;
              dat_o[sbsd_pkg::ST_MODE_FAULT_FLAG] <= mode_fault_flag;
            end
            sbsd_pkg::REG_DATA: dat_o[7:0] <= rxBuf;
            sbsd_pkg::REG_CTRL: dat_o[7:0] <= ctrlReg;
          endcase
        end
      end
    end
  end

  // Baud configuration is never locked by an active transfer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      baudReg <= sbsd_pkg::BAUD_RST;
    end else if (wrAcc && idx == sbsd_pkg::REG_BAUD) begin
      baudReg <= dat_i[7:0] & sbsd_pkg::BR_MASK;
    end
  end

  // A fault outranks a simultaneous software write of master select
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrlReg <= sbsd_pkg::CTRL_RST;
    end else begin
      if (ctrlWr) begin
        ctrlReg <= dat_i[7:0];
      end
      if (modfEvent) begin
        ctrlReg[sbsd_pkg::CT_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // Bit-rate generator; reserved rate codes act as the largest
  assign rateSel = baudReg[sbsd_pkg::BR_RATE_MSB:0] > sbsd_pkg::RATE_MAX ?
    sbsd_pkg::RATE_MAX : baudReg[sbsd_pkg::BR_RATE_MSB:0];
  assign halfLimit = 8'((9'h001 << rateSel) - 9'h001);
  assign halfTick = preCnt == baudReg[sbsd_pkg::BR_PRE_MSB:sbsd_pkg::BR_PRE_LSB] &&
    divCnt == halfLimit;

  // Counters idle at zero so the first edge comes half a bit after start
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      preCnt <= '0;
      divCnt <= '0;
    end else if (state != sbsd_pkg::S_MXFER || xferDone) begin
      preCnt <= '0;
      divCnt <= '0;
    end else if (preCnt == baudReg[sbsd_pkg::BR_PRE_MSB:sbsd_pkg::BR_PRE_LSB]) begin
      preCnt <= '0;
      divCnt <= halfTick ? 8'h00 : divCnt + 8'h01;
    end else begin
      preCnt <= preCnt + 3'h1;
    end
  end

  // Edge events; idle-low clock, sample on rise, shift on fall
  always_comb begin
    rise = 1'b0;
    fall = 1'b0;
    if (state == sbsd_pkg::S_MXFER) begin
      rise = halfTick & ~sckReg;
      fall = halfTick & sckReg;
    end else if (state == sbsd_pkg::S_SXFER) begin
      rise = pinSync[sbsd_pkg::PIN_SCK] & ~sckPrev;
      fall = ~pinSync[sbsd_pkg::PIN_SCK] & sckPrev;
    end
  end

  assign inBit = master ? pinSync[sbsd_pkg::PIN_MISO] : pinSync[sbsd_pkg::PIN_MOSI];
  assign xferDone = fall && shiftCnt == sbsd_pkg::BITS_PER_XFER - 4'h1 && !abort;
  assign rxByte = {shifter[6:0], sampleBit};
  assign modfEvent = en & master & fde & ~soe & ~pinSync[sbsd_pkg::PIN_SS];
  assign abort = ~en | modfEvent |
    (state == sbsd_pkg::S_SXFER & pinSync[sbsd_pkg::PIN_SS]);
  assign move = txBufFull & ~abort &
    (xferDone | (~shiftLoaded & state == sbsd_pkg::S_IDLE));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= sbsd_pkg::S_IDLE;
    end else if (abort) begin
      state <= sbsd_pkg::S_IDLE;
    end else begin
      unique case (state)
        sbsd_pkg::S_IDLE: begin
          if (master && shiftLoaded) begin
            state <= sbsd_pkg::S_MXFER;
          end else if (!master && !pinSync[sbsd_pkg::PIN_SS]) begin
            state <= sbsd_pkg::S_SXFER;
          end
        end
        sbsd_pkg::S_MXFER: begin
          if (xferDone && !move) begin
            state <= sbsd_pkg::S_IDLE;
          end
        end
        sbsd_pkg::S_SXFER: begin
          if (xferDone) begin
            state <= sbsd_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // Shifter, bit count and serial clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shifter <= '0;
      shiftCnt <= '0;
      sampleBit <= 1'b0;
      sckReg <= 1'b0;
      shiftLoaded <= 1'b0;
    end else if (abort) begin
      shiftCnt <= '0;
      sckReg <= 1'b0;
      shiftLoaded <= 1'b0;
    end else begin
      if (state == sbsd_pkg::S_MXFER && halfTick) begin
        sckReg <= ~sckReg;
      end
      if (rise) begin
        sampleBit <= inBit;
      end
      if (move) begin
        shifter <= txBuf;
        shiftLoaded <= 1'b1;
      end else if (fall) begin
        shifter <= rxByte;
      end
      if (xferDone) begin
        shiftCnt <= '0;
        if (!move) begin
          shiftLoaded <= 1'b0;
        end
      end else if (fall) begin
        shiftCnt <= shiftCnt + 4'h1;
      end
    end
  end

  // Transmit buffer; only an armed write reaches it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txBuf <= sbsd_pkg::DATA_RST;
      txBufFull <= 1'b0;
      txEmpty <= 1'b1;
      txArm <= 1'b0;
    end else if (!en) begin
      txBufFull <= 1'b0;
      txEmpty <= 1'b1;
      txArm <= 1'b0;
    end else begin
      if (dataWrOk) begin
        txBuf <= dat_i[7:0];
        txBufFull <= 1'b1;
      end else if (move) begin
        txBufFull <= 1'b0;
      end
      if (move) begin
        txEmpty <= 1'b1;
      end else if (dataWrOk) begin
        txEmpty <= 1'b0;
      end
      if (dataWr) begin
        txArm <= 1'b0;
      end else if (statusRd && txEmpty) begin
        txArm <= 1'b1;
      end
    end
  end

  // Receive buffer; a clear in the same cycle frees room for the new byte
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxBuf <= sbsd_pkg::DATA_RST;
      rxFull <= 1'b0;
      rxArm <= 1'b0;
    end else if (!en) begin
      rxFull <= 1'b0;
      rxArm <= 1'b0;
    end else begin
      if (xferDone && (!rxFull || rxClear)) begin
        rxBuf <= rxByte;
        rxFull <= 1'b1;
      end else if (rxClear) begin
        rxFull <= 1'b0;
      end
      if (dataRd) begin
        rxArm <= 1'b0;
      end else if (statusRd && rxFull) begin
        rxArm <= 1'b1;
      end
    end
  end

  // Mode fault flag; a new fault wins over the clearing write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_fault_flag <= 1'b0;
      modfArm <= 1'b0;
    end else begin
      if (modfEvent) begin
        mode_fault_flag <= 1'b1;
      end else if (ctrlWr && modfArm) begin
        mode_fault_flag <= 1'b0;
      end
      if (ctrlWr) begin
        modfArm <= 1'b0;
      end else if (statusRd && mode_fault_flag) begin
        modfArm <= 1'b1;
      end
    end
  end

  // Pin drive; a fault clears master select, releasing the sck, mosi and select outputs
  assign sckOut = sckReg;
  assign sckOe = en & master;
  assign mosiOut = shifter[7];
  assign mosiOe = en & master;
  assign misoOut = shifter[7];
  assign misoOe = en & ~master & ~pinSync[sbsd_pkg::PIN_SS];
  assign ssOut = state != sbsd_pkg::S_MXFER;
  assign select_output_enable = en & master & fde & soe;
  assign txIrq = txEmpty & tie;

  localparam int TXE_BOUND = sbsd_pkg::TXE_SET_CYCLES;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_idle_write;
    dataWrOk && state == sbsd_pkg::S_IDLE && !shiftLoaded && !txBufFull;
  endsequence
  sequence s_rx_armed_read;
    rxArm && dataRd && !xferDone;
  endsequence

  property p_txe_refill;
    s_idle_write ##1 en |-> ##[1:TXE_BOUND] txEmpty;
  endproperty
  a_txe_refill: assert property (p_txe_refill) else $error("flag not back");

  property p_discard;
    dataWr && !txArm |=> $stable(txBuf);
  endproperty
  a_discard: assert property (p_discard) else $error("unarmed write taken");

  property p_status_zero;
    access && !we_i && mapped && idx == sbsd_pkg::REG_STATUS |=>
      dat_o[6] == 1'b0 && dat_o[3:0] == 4'h0 && ack_o;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("reserved bit set");

  property p_rxf_clear;
    s_rx_armed_read |=> !rxFull;
  endproperty
  a_rxf_clear: assert property (p_rxf_clear) else $error("rx flag kept");

  property p_overrun;
    xferDone && rxFull && !rxClear |=> $stable(rxBuf) && rxFull;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun overwrote");

  property p_rxf_set;
    xferDone && en |=> rxFull;
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("rx flag not set");

  property p_mode_fault_flag;
    modfEvent |=> mode_fault_flag && !master && state == sbsd_pkg::S_IDLE && !sckOe;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("fault not handled");

  property p_mode_fault_flag_only;
    !mode_fault_flag && !(en && master && fde && !soe) |=> !mode_fault_flag;
  endproperty
  a_mode_fault_flag_only: assert property (p_mode_fault_flag_only) else $error("stray fault");

  property p_disable;
    !en |=> txEmpty && !rxFull && state == sbsd_pkg::S_IDLE && !shiftLoaded;
  endproperty
  a_disable: assert property (p_disable) else $error("disable incomplete");
endmodule // sbsd_core

//--- sbsd_remote_slave.sv
// Remote serial slave model facing the block in master mode
module sbsd_remote_slave (
  // Link
  input wire logic sck,
  input wire logic mosi,
  input wire logic ssN,
  output logic miso,
  // Reply base, byte k answers reply + k
  input wire logic [7:0] reply
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh = 8'h00;
  logic [7:0] gotQ[$];
  int bitCnt = 0;
  initial miso = 1'b1;
  // Sample on rise, MSB first; eight rises make a byte
  always @(posedge sck) if (!ssN) begin
    sh = {sh[6:0], mosi};
    bitCnt++;
    if (bitCnt == 8) begin
      gotQ.push_back(sh);
      bitCnt = 0;
      sh = reply + 8'(gotQ.size());
    end
  end
  always @(negedge sck) if (!ssN) miso = sh[7];
  always @(negedge ssN) begin
    bitCnt = 0;
    sh = reply + 8'(gotQ.size());
    miso = sh[7];
  end
  // Released line must not keep a stale bit
  always @(posedge ssN) miso = ~miso;
endmodule // sbsd_remote_slave

//--- test_spi_baud_status_data.sv
// Self-checking bench for the serial bit-rate, status and data block
module test_spi_baud_status_data;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_BR = 8'h00;
  localparam logic [7:0] A_ST = 8'h04;
  localparam logic [7:0] A_DT = 8'h08;
  localparam logic [7:0] A_CT = 8'h0C;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ssDrv = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, ssOut, select_output_enable, txIrq, slvMiso;
  logic sckW, mosiW, ssW, misoW;
  logic [7:0] reply = 8'h5A;
  int failures = 0;
  int compares = 0;
  assign sckW = sckOe ? sckOut : 1'b0;
  assign mosiW = mosiOe ? mosiOut : 1'b0;
  assign ssW = select_output_enable ? ssOut : ssDrv;
  assign misoW = misoOe ? misoOut : slvMiso;
  always #50 clk_sys = ~clk_sys;
  sbsd_core dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .adr_i(adr),
    .we_i(we), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .sckIn(sckW),
    .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .ssIn(ssW), .ssOut(ssOut),
    .select_output_enable(select_output_enable), .txIrq(txIrq));
  sbsd_remote_slave remote_u (.sck(sckW), .mosi(mosiW), .ssN(ssW), .miso(slvMiso),
    .reply(reply));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(logic [7:0] a, logic w, logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("bus ack", 32'(n < 50), 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
    logic [31:0] q;
    wb(a, 1'b0, 8'h00, q);
    check(nm, q, {24'h0, exp});
  endtask
  task automatic waitSs(int lim);
    for (int n = 0; n < lim && ssOut !== 1'b1; n++) @(posedge clk_sys);
  endtask
  task automatic t_idle();
    wr(A_CT, 8'h53);
    wr(A_DT, 8'hA5);
    repeat (20) @(posedge clk_sys);
    check("unarmed ss", ssOut, 1'b1);
    rd(A_ST, 8'h20, "status rst");
    rd(A_DT, 8'h00, "data rst");
    rd(A_BR, 8'h00, "baud rst");
    wr(A_ST, 8'hFF);
    rd(A_ST, 8'h20, "status ro");
    wr(A_BR, 8'hFF);
    rd(A_BR, 8'h7F, "baud rw");
    rd(8'h10, 8'h00, "unmapped");
  endtask
  task automatic xfer(logic [2:0] pre, logic [3:0] rate, logic [7:0] tx);
    int n, c, k;
    k = remote_u.gotQ.size();
    wr(A_BR, {1'b0, pre, rate});
    rd(A_ST, 8'h20, "status arm");
    wr(A_DT, tx);
    rd(A_ST, 8'h20, "txe back");
    for (n = 0; n < 3000 && sckOut !== 1'b1; n++) @(posedge clk_sys);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (c < 3000 && sckOut !== 1'b0);
    do begin
      @(posedge clk_sys);
      c++;
    end while (c < 3000 && sckOut !== 1'b1);
    check("sck period", c, 2 * (pre + 1) * (1 << (rate > 8 ? 8 : rate)));
    waitSs(20000);
    check("byte out", remote_u.gotQ[k], tx);
    rd(A_ST, 8'hA0, "rx full");
    rd(A_DT, reply + 8'(k), "rx data");
    rd(A_ST, 8'h20, "rx clear");
  endtask
  task automatic t_queue();
    int k;
    k = remote_u.gotQ.size();
    wr(A_CT, 8'h73);
    wr(A_BR, 8'h03);
    rd(A_ST, 8'h20, "q arm");
    check("irq on", txIrq, 1'b1);
    wr(A_DT, 8'h3C);
    rd(A_ST, 8'h20, "q txe");
    wr(A_DT, 8'hC3);
    rd(A_ST, 8'h00, "q full");
    check("irq off", txIrq, 1'b0);
    waitSs(2000);
    check("q byte1", remote_u.gotQ[k], 8'h3C);
    check("q byte2", remote_u.gotQ[k + 1], 8'hC3);
    rd(A_ST, 8'hA0, "q status");
    rd(A_DT, reply + 8'(k), "overrun");
    rd(A_ST, 8'h20, "q clear");
  endtask
  task automatic t_fault();
    wr(A_CT, 8'h50);
    ssDrv <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(A_ST, 8'h20, "no fdet");
    wr(A_CT, 8'h51);
    repeat (6) @(posedge clk_sys);
    check("fault sck", sckOe, 1'b0);
    ssDrv <= 1'b1;
    rd(A_CT, 8'h41, "fault master_select");
    rd(A_ST, 8'h30, "fault set");
    wr(A_CT, 8'h41);
    rd(A_ST, 8'h20, "fault clr");
  endtask
  task automatic t_abort();
    int k;
    k = remote_u.gotQ.size();
    wr(A_CT, 8'h53);
    wr(A_BR, 8'h07);
    rd(A_ST, 8'h20, "ab arm");
    wr(A_DT, 8'h55);
    repeat (300) @(posedge clk_sys);
    check("ab busy", ssOut, 1'b0);
    wr(A_CT, 8'h00);
    // Abort lands one edge after the control write takes effect
    repeat (2) @(posedge clk_sys);
    check("ab ss", ssOut, 1'b1);
    rd(A_ST, 8'h20, "ab status");
    check("ab bytes", remote_u.gotQ.size(), k);
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #5_000_000;
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_idle();
    // Synchronised input needs a half bit of at least three clocks
    xfer(3'h0, 4'h2, 8'h96);
    xfer(3'h7, 4'h0, 8'h01);
    xfer(3'h2, 4'h3, 8'hF0);
    xfer(3'h0, 4'h8, 8'h80);
    xfer(3'h1, 4'h9, 8'h7E);
    t_queue();
    t_fault();
    t_abort();
    give_verdict();
  end
endmodule // test_spi_baud_status_data
